//--- hdl/shreg_pkg.sv
/*
   Shared constants and types for the octal shift/storage register block:
   register offsets, status field positions, reset values and state codes.
   Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`default_nettype none
package shreg_pkg;
   localparam int REG_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int CTRL_W = 1;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LOAD = 8'h08;

   localparam logic [0:0] CTRL_RESET = 1'h0;
   localparam int CTRL_FIFO_SRC = 0;

   localparam int ST_EMPTY = 8;
   localparam int ST_FULL = 9;
   localparam int ST_MODE = 10;
   localparam int ST_DRIVE = 12;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {MODE_HOLD = 2'h0, MODE_SHR = 2'h1, MODE_SHL = 2'h2, MODE_LOAD = 2'h3} mode_type;
   typedef enum logic [1:0] {SEL_NONE = 2'h0, SEL_CTRL = 2'h1, SEL_STATUS = 2'h2, SEL_LOAD = 2'h3} sel_type;
   typedef enum logic [2:0] {WR_IDLE = 3'h1, WR_PUSH = 3'h2, WR_RESP = 3'h4} wr_state_type;
   typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_RESP = 2'h2} rd_state_type;
endpackage
`default_nettype wire

//--- hdl/stream_if.sv
/*
   Valid/ready word stream between the block's own modules.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- hdl/word_fifo.sv
/*
   Synchronous FIFO with valid/ready on both sides.
   Assumes DEPTH is a power of two; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Streams
   stream_if.snk in_s,
   stream_if.src out_s,
   // Levels
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   wire push = in_s.valid & in_s.ready;
   wire pop = out_s.valid & out_s.ready;

   // Extra pointer bit tells a full ring from an empty one
   assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign in_s.ready = ~full;
   assign out_s.valid = ~empty;
   assign out_s.data = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_r[AW-1:0]] <= in_s.data;
   end
endmodule
`default_nettype wire

//--- hdl/shift_core.sv
/*
   The storage register itself: hold, shift right, shift left, load.
   Assumes step is a one-cycle pulse and clr_n is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module shift_core #(
   parameter int W = 8
) (
   // Clock and clears
   input wire logic clk,
   input wire logic rst,
   input wire logic clr_n,
   // Operation
   input wire logic step,
   input wire shreg_pkg::mode_type mode,
   input wire logic ser_r_in,
   input wire logic ser_l_in,
   input wire logic [W-1:0] load_data,
   // Contents
   output logic [W-1:0] q_r
);
   logic [W-1:0] q_nxt;

   always_comb
   begin
      case (mode)
         shreg_pkg::MODE_HOLD: q_nxt = q_r;
         shreg_pkg::MODE_SHR: q_nxt = {q_r[W-2:0], ser_r_in};
         shreg_pkg::MODE_SHL: q_nxt = {ser_l_in, q_r[W-1:1]};
         shreg_pkg::MODE_LOAD: q_nxt = load_data;
         default: q_nxt = q_r;
      endcase
   end

   // Clear beats any mode or step
   always_ff @(posedge clk)
   begin
      if (rst | ~clr_n)
         q_r <= '0;
      else if (step)
         q_r <= q_nxt;
   end
endmodule
`default_nettype wire

//--- hdl/octal_universal_shift_register.sv
/*
   Top of the octal universal shift/storage register with an AXI4-Lite
   control slave and an 8-word FIFO that can feed parallel loads.
   Assumes all pins are synchronous to CLK and the shift clock pin is
   slower than CLK/2, so each of its rising edges is seen once.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Eight-bit edge-triggered storage register
// - Active-low clear zeroes all bits
// - State changes only on shift clock rise or clear
// - Two mode selects choose the operation
// - Both selects high loads parallel port (loads a FIFO word instead while the CTRL_FIFO_SRC bit is set, or holds if the FIFO is empty)
// - Select low/high pair shifts right
// - Select high/low pair shifts left
// - Both selects low holds contents
// - Each bit drives its own port bit
// - Either enable high floats the port
// - Operations continue while port floats
// - Load mode also floats the port
// - End bits drive serial outputs always
module octal_universal_shift_register #(
   parameter int DEPTH = shreg_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Register pins
   input wire logic SHIFT_CLOCK,
   input wire logic RIGHT_SHIFT_SERIAL_IN,
   input wire logic LEFT_SHIFT_SERIAL_IN,
   input wire logic MODE_SELECT_LO,
   input wire logic MODE_SELECT_HI,
   input wire logic CLEAR_N,
   input wire logic PORT_DRIVE_EN_A_N,
   input wire logic PORT_DRIVE_EN_B_N,
   // Parallel port, split into its three signals
   input wire logic [shreg_pkg::REG_W-1:0] PARALLEL_PORT_I,
   output logic [shreg_pkg::REG_W-1:0] PARALLEL_PORT_O,
   output logic [shreg_pkg::REG_W-1:0] PARALLEL_PORT_OE,
   // Cascade outputs
   output logic SERIAL_OUT_LOW_END,
   output logic SERIAL_OUT_HIGH_END,
   // AXI4-Lite write
   input wire logic [shreg_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [shreg_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [shreg_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [shreg_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   localparam int W = shreg_pkg::REG_W;

   function automatic shreg_pkg::sel_type reg_decode(input logic [shreg_pkg::AXI_ADDR_W-1:0] a);
      logic [shreg_pkg::AXI_ADDR_W-1:0] w;
      w = {a[shreg_pkg::AXI_ADDR_W-1:2], 2'h0};
      case (w)
         shreg_pkg::OFS_CTRL: reg_decode = shreg_pkg::SEL_CTRL;
         shreg_pkg::OFS_STATUS: reg_decode = shreg_pkg::SEL_STATUS;
         shreg_pkg::OFS_LOAD: reg_decode = shreg_pkg::SEL_LOAD;
         default: reg_decode = shreg_pkg::SEL_NONE;
      endcase
   endfunction

   // Register pin side
   logic shift_clock_prev_r;
   logic [W-1:0] reg_q;
   logic [W-1:0] drive_oe_r;
   logic [shreg_pkg::CTRL_W-1:0] ctrl_r;
   logic fifo_full;
   logic fifo_empty;

   stream_if #(.W(W)) load_in ();
   stream_if #(.W(W)) load_out ();

   wire step = SHIFT_CLOCK & ~shift_clock_prev_r;
   wire shreg_pkg::mode_type pin_mode = shreg_pkg::mode_type'({MODE_SELECT_HI, MODE_SELECT_LO});
   wire load_mode = (pin_mode == shreg_pkg::MODE_LOAD);
   wire fifo_src = ctrl_r[shreg_pkg::CTRL_FIFO_SRC];
   // A FIFO-sourced load with nothing queued holds rather than load stale data
   wire load_starved = fifo_src & load_mode & fifo_empty;
   wire shreg_pkg::mode_type core_mode = load_starved ? shreg_pkg::MODE_HOLD : pin_mode;
   wire [W-1:0] load_data = fifo_src ? load_out.data : PARALLEL_PORT_I;
   wire port_enabled = ~PORT_DRIVE_EN_A_N & ~PORT_DRIVE_EN_B_N & ~load_mode;

   // A pop only when the load really happens, so a clear never eats a word
   assign load_out.ready = step & fifo_src & load_mode & CLEAR_N;

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         shift_clock_prev_r <= 1'b0;
      else
         shift_clock_prev_r <= SHIFT_CLOCK;
   end

   // Port enables never reach the core, so it keeps working while the port floats
   shift_core #(.W(W)) core (
      .clk(CLK),
      .rst(SYS_RST),
      .clr_n(CLEAR_N),
      .step(step),
      .mode(core_mode),
      .ser_r_in(RIGHT_SHIFT_SERIAL_IN),
      .ser_l_in(LEFT_SHIFT_SERIAL_IN),
      .load_data(load_data),
      .q_r(reg_q)
   );

   word_fifo #(.WIDTH(W), .DEPTH(DEPTH)) load_fifo (
      .clk(CLK),
      .rst(SYS_RST),
      .in_s(load_in),
      .out_s(load_out),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   // Enable is registered: the port follows its controls one CLK later
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         drive_oe_r <= '0;
      else
         drive_oe_r <= {W{port_enabled}};
   end

   assign PARALLEL_PORT_O = reg_q;
   assign PARALLEL_PORT_OE = drive_oe_r;
   assign SERIAL_OUT_LOW_END = reg_q[0];
   assign SERIAL_OUT_HIGH_END = reg_q[W-1];

   // Register bus: write channel
   shreg_pkg::wr_state_type wr_st_r;
   shreg_pkg::wr_state_type wr_st_nxt;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic aw_held_r;
   logic w_held_r;
   logic [shreg_pkg::AXI_ADDR_W-1:0] awaddr_r;
   logic [shreg_pkg::AXI_DATA_W-1:0] wdata_r;
   logic [3:0] wstrb_r;

   wire aw_fire = S_AXI_AWVALID & awready_r;
   wire w_fire = S_AXI_WVALID & wready_r;
   wire b_fire = bvalid_r & S_AXI_BREADY;
   wire both_held = aw_held_r & w_held_r;
   wire shreg_pkg::sel_type wr_sel = reg_decode(awaddr_r);
   wire wr_idle = (wr_st_r == shreg_pkg::WR_IDLE);
   wire push_req = (wr_sel == shreg_pkg::SEL_LOAD) & wstrb_r[0];
   wire ctrl_we = wr_idle & both_held & (wr_sel == shreg_pkg::SEL_CTRL) & wstrb_r[0];
   wire enter_resp = (wr_st_nxt == shreg_pkg::WR_RESP) & (wr_st_r != shreg_pkg::WR_RESP);

   // A full FIFO holds the write response back until a word drains
   assign load_in.valid = (wr_st_r == shreg_pkg::WR_PUSH);
   assign load_in.data = wdata_r[W-1:0];

   always_comb
   begin
      case (wr_st_r)
         shreg_pkg::WR_IDLE:
         begin
            if (both_held)
               wr_st_nxt = push_req ? shreg_pkg::WR_PUSH : shreg_pkg::WR_RESP;
            else
               wr_st_nxt = shreg_pkg::WR_IDLE;
         end
         shreg_pkg::WR_PUSH: wr_st_nxt = load_in.ready ? shreg_pkg::WR_RESP : shreg_pkg::WR_PUSH;
         shreg_pkg::WR_RESP: wr_st_nxt = b_fire ? shreg_pkg::WR_IDLE : shreg_pkg::WR_RESP;
         default: wr_st_nxt = shreg_pkg::WR_IDLE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         wr_st_r <= shreg_pkg::WR_IDLE;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
      end
      else
      begin
         wr_st_r <= wr_st_nxt;
         awready_r <= wr_idle & ~aw_held_r & ~aw_fire;
         wready_r <= wr_idle & ~w_held_r & ~w_fire;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else
      begin
         if (aw_fire)
            awaddr_r <= S_AXI_AWADDR;
         if (w_fire)
         begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
         aw_held_r <= aw_fire | (aw_held_r & ~b_fire);
         w_held_r <= w_fire | (w_held_r & ~b_fire);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= shreg_pkg::RESP_OKAY;
         ctrl_r <= shreg_pkg::CTRL_RESET;
      end
      else
      begin
         if (ctrl_we)
            ctrl_r <= wdata_r[shreg_pkg::CTRL_W-1:0];
         if (enter_resp)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == shreg_pkg::SEL_NONE) ? shreg_pkg::RESP_DECERR : shreg_pkg::RESP_OKAY;
         end
         else if (b_fire)
            bvalid_r <= 1'b0;
      end
   end

   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;

   // Register bus: read channel
   shreg_pkg::rd_state_type rd_st_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [shreg_pkg::AXI_DATA_W-1:0] rdata_r;
   logic [shreg_pkg::AXI_DATA_W-1:0] status_word;

   wire ar_fire = S_AXI_ARVALID & arready_r;
   wire r_fire = rvalid_r & S_AXI_RREADY;
   wire shreg_pkg::sel_type rd_sel = reg_decode(S_AXI_ARADDR);

   assign status_word[W-1:0] = reg_q;
   assign status_word[shreg_pkg::ST_EMPTY] = fifo_empty;
   assign status_word[shreg_pkg::ST_FULL] = fifo_full;
   assign status_word[shreg_pkg::ST_MODE +: 2] = pin_mode;
   assign status_word[shreg_pkg::ST_DRIVE] = drive_oe_r[0];
   assign status_word[shreg_pkg::AXI_DATA_W-1:shreg_pkg::ST_DRIVE+1] = '0;

   wire [shreg_pkg::AXI_DATA_W-1:0] rd_word =
      (rd_sel == shreg_pkg::SEL_CTRL) ? shreg_pkg::AXI_DATA_W'(ctrl_r) :
      (rd_sel == shreg_pkg::SEL_STATUS) ? status_word : '0;

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         rd_st_r <= shreg_pkg::RD_IDLE;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= shreg_pkg::RESP_OKAY;
         rdata_r <= '0;
      end
      else
      begin
         case (rd_st_r)
            shreg_pkg::RD_IDLE:
            begin
               arready_r <= ~ar_fire;
               if (ar_fire)
               begin
                  rd_st_r <= shreg_pkg::RD_RESP;
                  rvalid_r <= 1'b1;
                  rdata_r <= rd_word;
                  rresp_r <= (rd_sel == shreg_pkg::SEL_NONE) ? shreg_pkg::RESP_DECERR : shreg_pkg::RESP_OKAY;
               end
            end
            shreg_pkg::RD_RESP:
            begin
               if (r_fire)
               begin
                  rd_st_r <= shreg_pkg::RD_IDLE;
                  rvalid_r <= 1'b0;
               end
            end
            default: rd_st_r <= shreg_pkg::RD_IDLE;
         endcase
      end
   end

   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   wire act = step & CLEAR_N;
   wire port_load = act & load_mode & ~fifo_src;

   AST_CLEAR_ZEROES: assert property (!CLEAR_N |=> reg_q == '0)
      else $error("clear did not zero the register");
   AST_NO_STEP_NO_CHANGE: assert property (CLEAR_N && !step |=> $stable(reg_q))
      else $error("register changed without a shift clock rise");
   AST_PORT_LOAD: assert property (port_load |=> reg_q == $past(PARALLEL_PORT_I))
      else $error("parallel load took wrong data");
   AST_SHIFT_RIGHT: assert property (act && pin_mode == shreg_pkg::MODE_SHR
      |=> reg_q == {$past(reg_q[W-2:0]), $past(RIGHT_SHIFT_SERIAL_IN)})
      else $error("right shift wrong");
   AST_SHIFT_LEFT: assert property (act && pin_mode == shreg_pkg::MODE_SHL
      |=> reg_q == {$past(LEFT_SHIFT_SERIAL_IN), $past(reg_q[W-1:1])})
      else $error("left shift wrong");
   AST_HOLD_MODE: assert property (CLEAR_N && pin_mode == shreg_pkg::MODE_HOLD |=> $stable(reg_q))
      else $error("hold mode changed the register");
   AST_ENABLE_DISABLE: assert property (PORT_DRIVE_EN_A_N || PORT_DRIVE_EN_B_N |=> PARALLEL_PORT_OE == '0)
      else $error("port driven while an enable is high");
   AST_LOAD_FLOATS: assert property (load_mode |=> PARALLEL_PORT_OE == '0)
      else $error("port driven in load mode");
   AST_PORT_DRIVES: assert property (port_enabled |=> PARALLEL_PORT_OE == '1 && PARALLEL_PORT_O == reg_q)
      else $error("port not driven with contents");
   AST_FLOAT_STILL_SHIFTS: assert property ((PORT_DRIVE_EN_A_N || PORT_DRIVE_EN_B_N) && act
      && pin_mode == shreg_pkg::MODE_SHL
      |=> SERIAL_OUT_HIGH_END == $past(LEFT_SHIFT_SERIAL_IN))
      else $error("shift lost while port floats");
   AST_WRITE_ANSWERED: assert property (both_held && wr_idle && !push_req |-> ##1 bvalid_r)
      else $error("register write not answered");

   COV_LOAD: cover property (port_load ##[1:8] port_enabled);
   COV_SHIFT_RUN: cover property (act && pin_mode == shreg_pkg::MODE_SHR ##[1:20] act && pin_mode == shreg_pkg::MODE_SHL);
   COV_FIFO_FULL: cover property (fifo_full && load_out.valid && load_out.ready);
   COV_FIFO_LOAD: cover property (load_out.valid && load_out.ready);
endmodule
`default_nettype wire

//--- testbench/port_bus_model.sv
/*
   Far-side model of the shared parallel port: an outside bus driver.
   Assumes one clock; the bench asks it to drive through drv_en.
*/
`timescale 1ns/1ps
`default_nettype none
module port_bus_model (
   // Clock
   input wire logic clk,
   // Device side
   input wire logic [7:0] dev_o,
   input wire logic [7:0] dev_oe,
   // Bench side
   input wire logic drv_en,
   input wire logic [7:0] drv_val,
   output logic [7:0] bus,
   output logic clash
);
   logic [7:0] last_r = 8'h00;
   logic drive;
   // Drives only while the device has let go of every bit
   assign drive = drv_en & ~(|dev_oe);
   assign clash = drv_en & (|dev_oe);
   // A floating bus never keeps its last value, so stale data cannot pass for a load
   assign bus = (dev_oe & dev_o) | (~dev_oe & (drive ? drv_val : ~last_r));
   always_ff @(posedge clk)
   begin
      last_r <= bus;
   end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
/*
   Self-checking bench for the octal shift register: pin-level steps,
   port enables, FIFO-fed loads and AXI4-Lite register accesses.
   Assumes the design top and its package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, sclk = 1'b0, rsi = 1'b0, lsi = 1'b0, ms_lo = 1'b0, ms_hi = 1'b0;
   logic clear_n = 1'b1, en_a_n = 1'b0, en_b_n = 1'b0, drv_en = 1'b0, so_lo, so_hi, clash;
   logic [7:0] drv_val = 8'h00, port_i, port_o, port_oe, awaddr = 8'h00, araddr = 8'h00, q;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata, d, pins;
   logic [1:0] bresp, rresp, r;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   localparam logic [7:0] PAT = 8'hcb;

   always #12.5 clk = ~clk;
   assign pins = {22'h0, so_hi, so_lo, port_o};

   octal_universal_shift_register #(.DEPTH(8)) u_octal_universal_shift_register (
      .CLK(clk), .SYS_RST(rst), .SHIFT_CLOCK(sclk), .RIGHT_SHIFT_SERIAL_IN(rsi),
      .LEFT_SHIFT_SERIAL_IN(lsi), .MODE_SELECT_LO(ms_lo), .MODE_SELECT_HI(ms_hi), .CLEAR_N(clear_n),
      .PORT_DRIVE_EN_A_N(en_a_n), .PORT_DRIVE_EN_B_N(en_b_n), .PARALLEL_PORT_I(port_i),
      .PARALLEL_PORT_O(port_o), .PARALLEL_PORT_OE(port_oe), .SERIAL_OUT_LOW_END(so_lo),
      .SERIAL_OUT_HIGH_END(so_hi), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   port_bus_model u_port_bus_model (.clk(clk), .dev_o(port_o), .dev_oe(port_oe), .drv_en(drv_en),
      .drv_val(drv_val), .bus(port_i), .clash(clash));

   task end_of_test;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] pv(input logic [7:0] v);
      return {22'h0, v[7], v[0], v};
   endfunction

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= dv;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      dv = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic mode(input logic [1:0] m);
      @(posedge clk);
      ms_hi <= m[1];
      ms_lo <= m[0];
   endtask

   // One rise of the shift clock, held high for n cycles, then low again
   task automatic pulse(input int n, input logic r_in, input logic l_in);
      @(posedge clk);
      sclk <= 1'b1;
      rsi <= r_in;
      lsi <= l_in;
      repeat (n) @(posedge clk);
      sclk <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (clash === 1'b1)
         chk({31'h0, clash}, 32'h0);
      if (cyc == 6000)
      begin
         n_fail++;
         $display("Error t=%0t timeout", $time);
         end_of_test;
      end
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(pins, 32'h0);
      chk({24'h0, port_oe}, 32'hff);
      axi_rd(shreg_pkg::OFS_STATUS, d, r);
      chk(d, 32'h1100);
      mode(2'h3);
      repeat (2) @(posedge clk);
      #1;
      chk({24'h0, port_oe}, 32'h0);
      @(posedge clk);
      drv_en <= 1'b1;
      drv_val <= 8'ha5;
      pulse(1, 1'b0, 1'b0);
      q = 8'ha5;
      chk(pins, pv(q));
      @(posedge clk);
      drv_en <= 1'b0;
      mode(2'h0);
      pulse(1, 1'b1, 1'b1);
      chk(pins, pv(q));
      for (int m = 1; m < 3; m++)
      begin
         mode(m[1:0]);
         for (int i = 0; i < 8; i++)
         begin
            pulse(1, PAT[i], ~PAT[i]);
            q = (m == 1) ? {q[6:0], PAT[i]} : {~PAT[i], q[7:1]};
            chk(pins, pv(q));
         end
      end
      // A long high phase of the shift clock must still count as one step
      pulse(4, 1'b1, 1'b1);
      q = {1'b1, q[7:1]};
      chk(pins, pv(q));
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         en_a_n <= (k == 0);
         en_b_n <= (k == 1);
         repeat (2) @(posedge clk);
         #1;
         chk({24'h0, port_oe}, 32'h0);
         pulse(1, 1'b0, ~q[0]);
         q = {~q[0], q[7:1]};
         chk(pins, pv(q));
      end
      @(posedge clk);
      clear_n <= 1'b0;
      @(posedge clk);
      clear_n <= 1'b1;
      @(posedge clk);
      #1;
      q = 8'h00;
      chk(pins, pv(q));
      axi_wr(shreg_pkg::OFS_CTRL, 32'h1, r);
      chk({30'h0, r}, {30'h0, shreg_pkg::RESP_OKAY});
      axi_rd(shreg_pkg::OFS_CTRL, d, r);
      chk(d, 32'h1);
      for (int i = 0; i < 8; i++)
         axi_wr(shreg_pkg::OFS_LOAD, {24'h0, 8'h90 + i[7:0]}, r);
      chk({30'h0, r}, {30'h0, shreg_pkg::RESP_OKAY});
      axi_rd(shreg_pkg::OFS_STATUS, d, r);
      chk({22'h0, d[9:8]}, 32'h2);
      mode(2'h3);
      repeat (2) @(posedge clk);
      drv_en <= 1'b1;
      drv_val <= 8'h5a;
      // The outside bus stays busy with other data while the FIFO drains
      for (int i = 0; i < 8; i++)
      begin
         pulse(1, 1'b0, 1'b0);
         q = 8'h90 + i[7:0];
         chk(pins, pv(q));
      end
      axi_rd(shreg_pkg::OFS_STATUS, d, r);
      chk({22'h0, d[9:8]}, 32'h1);
      // An empty FIFO turns the load step into a hold
      pulse(1, 1'b0, 1'b0);
      chk(pins, pv(q));
      @(posedge clk);
      drv_en <= 1'b0;
      axi_wr(8'h40, 32'h1, r);
      chk({30'h0, r}, {30'h0, shreg_pkg::RESP_DECERR});
      axi_rd(8'h40, d, r);
      chk({d[29:0], r}, {30'h0, shreg_pkg::RESP_DECERR});
      end_of_test;
   end
endmodule
`default_nettype wire
